/* rtl/crs_pkg.sv */
// Purpose: Constants and carrier types for the channel reset and status registers
// Assumes: Registers are reached through the management serial station port
// Notes: Offsets are register addresses within the device address
package crs_pkg;
  localparam logic [4:0] DEV_ADDR = 5'h1E;
  localparam logic [15:0] RESET_CTRL_ADDR = 16'h000E;
  localparam logic [15:0] STATUS_ONE_ADDR = 16'h000F;
  localparam logic [15:0] RESET_CTRL_RST = 16'h0000;
  localparam logic [15:0] STATUS_ONE_RST = 16'h0000;
  // Reset control field positions
  localparam int PATH_RST_BIT = 3;
  localparam int TXQ_CLR_BIT = 2;
  localparam int RXQ_CLR_BIT = 1;
  localparam int RSV_LO_BIT = 0;
  localparam logic [3:0] RSV_MID_RST = 4'h0;
  // Status one field positions
  localparam int PATTERN_BIT = 15;
  localparam int HOST_ALIGN_BIT = 14;
  localparam int SIG_LOST_BIT = 13;
  localparam int AUTOZERO_BIT = 12;
  localparam int GAIN_LOCK_BIT = 11;
  localparam int SYNC_BIT = 10;
  localparam int RSV9_BIT = 9;
  localparam int CODE_VIOL_BIT = 8;
  localparam int TXQ_UNDER_BIT = 7;
  localparam int TXQ_OVER_BIT = 6;
  localparam int RXQ_UNDER_BIT = 5;
  localparam int RXQ_OVER_BIT = 4;
  localparam int SYS_LINK_BIT = 3;
  localparam int INT_LINK_BIT = 2;
  localparam int HOST_PLL_BIT = 1;
  localparam int LINE_PLL_BIT = 0;
  // Bits that latch low (hold a loss); the rest latch high, bit 15 is live
  localparam logic [15:0] LATCH_LOW_MASK = 16'h5C0F;
  localparam logic [15:0] LATCH_HIGH_MASK = 16'h23F0;
  localparam logic [15:0] LIVE_MASK = 16'h8000;
  // Channel operating modes, used to qualify mode-dependent bits
  typedef enum logic [1:0] {
    CRS_MODE_10G = 2'h0,
    CRS_MODE_10GKR = 2'h1,
    CRS_MODE_1GKX = 2'h2
  } crs_mode_e;
  // Live status conditions from the channel datapath
  typedef struct packed {
    logic linePatternMatch;
    logic hostLaneAligned;
    logic lineSignalLost;
    logic lineAutozeroComplete;
    logic lineGainLoopLocked;
    logic lineSyncAchieved;
    logic rsvEvent;
    logic lineCodeViolation;
    logic txQueueUnderflow;
    logic txQueueOverflow;
    logic rxQueueUnderflow;
    logic rxQueueOverflow;
    logic systemReceiveLinkGood;
    logic internalAlignLinkGood;
    logic hostSerdesPllLocked;
    logic lineSerdesPllLocked;
  } crs_status_s;
  // Register access request from the management station
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [4:0] devAddr;
    logic [15:0] regAddr;
    logic [15:0] wrData;
  } crs_req_s;
  // Reset pulses to the datapath
  typedef struct packed {
    logic channelPathReset;
    logic transmitQueueClear;
    logic receiveQueueClear;
  } crs_pulse_s;
endpackage : crs_pkg

/* rtl/crs_latch_bit.sv */
// Purpose: One status bit that latches high, latches low, or follows live
// Assumes: Read strobe is one cycle wide
// Notes: An event in the read cycle is kept, so set beats reload
`timescale 1ns/100ps
module crs_latch_bit #(
  parameter logic [1:0] KIND = 2'h0
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic live,
  input wire logic rdClr,
  output logic held
);
  logic held_q;
  logic held_d;
  // KIND 0 latches high, 1 latches low, 2 is live
  always_comb begin
    held_d = held_q;
    case (KIND)
      2'h0: held_d = rdClr ? live : (held_q | live);
      2'h1: held_d = rdClr ? live : (held_q & live);
      default: held_d = live;
    endcase
  end
  // Latch state; latched-low bits start at zero like the register default
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      held_q <= 1'h0;
    end else begin
      held_q <= held_d;
    end
  end
  assign held = held_q;
endmodule : crs_latch_bit

/* rtl/crs_regs.sv */
// Purpose: Channel reset control and latched channel status registers
// Assumes: Management station decodes the frame into one-cycle read and write strobes
// Notes: Read data is registered one cycle after the read strobe
//
// What this block does
// - Registers sit at device 0x1E, offsets 0x000E and 0x000F, reset zero.
// - Path reset bit 3 resets transmit and receive logic, not management registers.
// - Bit 2 clears the transmit queue, in 10G mode only.
// - Bit 1 clears the receive queue, in 10G mode only.
// - Each reset bit returns to zero by itself next clock.
// - Reset register bits 15 to 8 always read zero.
// - Bit 15 shows pattern match in 10G and 1GKX modes, else zero.
// - Bit 14 reports host lane alignment, latched low.
// - Bit 13 latches high on line signal loss.
// - Bit 12 shows autozero complete, latched low.
// - Bit 11 shows gain loop locked, latched low.
// - Bit 10 shows line sync achieved, latched low.
// - Bit 8 latches high on code violation or disparity error.
// - Bit 7 latches high on transmit queue underflow, not in 1GKX.
// - Bit 6 latches high on transmit queue overflow in 10GKR and 10G.
// - Bit 5 latches high on receive queue underflow, not in 1GKX.
// - Bit 4 latches high on receive queue overflow, in every mode.
// - Bit 3 shows system receive link good in 10G, latched low.
// - Bit 2 shows internal align link good, latched low.
// - Bit 1 shows host serdes PLL locked, latched low.
// - Bit 0 shows line serdes PLL locked, latched low.
`timescale 1ns/100ps
module crs_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire crs_pkg::crs_req_s req,
  input wire crs_pkg::crs_mode_e mode,
  input wire crs_pkg::crs_status_s status,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic channelPathReset,
  output logic transmitQueueClear,
  output logic receiveQueueClear
);
  // Address match helper, used for read and write decode
  function automatic logic hit(input crs_pkg::crs_req_s r, input logic [15:0] a);
    hit = (r.devAddr == crs_pkg::DEV_ADDR) && (r.regAddr == a);
  endfunction : hit

  logic wrReset;
  logic rdStatus;
  logic rdReset;
  assign wrReset = req.wrStb && hit(req, crs_pkg::RESET_CTRL_ADDR);
  assign rdStatus = req.rdStb && hit(req, crs_pkg::STATUS_ONE_ADDR);
  assign rdReset = req.rdStb && hit(req, crs_pkg::RESET_CTRL_ADDR);

  // Reserved writable bits 7:4 and 0 store; the pulse bits never store
  logic [3:0] rsvMid_q;
  logic rsvLo_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsvMid_q <= crs_pkg::RSV_MID_RST;
      rsvLo_q <= crs_pkg::RESET_CTRL_RST[crs_pkg::RSV_LO_BIT];
    end else if (wrReset) begin
      rsvMid_q <= req.wrData[7:4];
      rsvLo_q <= req.wrData[crs_pkg::RSV_LO_BIT];
    end
  end

  // Self-clearing reset pulses: high exactly one clock after the write
  crs_pkg::crs_pulse_s pulse_q;
  crs_pkg::crs_pulse_s pulse_d;
  always_comb begin
    pulse_d = '0;
    if (wrReset) begin
      pulse_d.channelPathReset = req.wrData[crs_pkg::PATH_RST_BIT];
      // Queue clears only mean something in 10G; the KR queue self-centres
      pulse_d.transmitQueueClear = req.wrData[crs_pkg::TXQ_CLR_BIT] && (mode == crs_pkg::CRS_MODE_10G);
      pulse_d.receiveQueueClear = req.wrData[crs_pkg::RXQ_CLR_BIT] && (mode == crs_pkg::CRS_MODE_10G);
    end
  end
  // The path reset goes to the datapath only; these registers keep their state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= pulse_d;
    end
  end
  assign channelPathReset = pulse_q.channelPathReset;
  assign transmitQueueClear = pulse_q.transmitQueueClear;
  assign receiveQueueClear = pulse_q.receiveQueueClear;

  // Mode qualification of live conditions before latching
  logic [15:0] live;
  logic is1gkx;
  assign is1gkx = (mode == crs_pkg::CRS_MODE_1GKX);
  always_comb begin
    live = status;
    live[crs_pkg::PATTERN_BIT] = status.linePatternMatch && (mode != crs_pkg::CRS_MODE_10GKR);
    live[crs_pkg::HOST_ALIGN_BIT] = status.hostLaneAligned;
    live[crs_pkg::SIG_LOST_BIT] = status.lineSignalLost;
    live[crs_pkg::AUTOZERO_BIT] = status.lineAutozeroComplete;
    live[crs_pkg::GAIN_LOCK_BIT] = status.lineGainLoopLocked;
    live[crs_pkg::SYNC_BIT] = status.lineSyncAchieved;
    live[crs_pkg::CODE_VIOL_BIT] = status.lineCodeViolation;
    live[crs_pkg::TXQ_UNDER_BIT] = status.txQueueUnderflow && !is1gkx;
    live[crs_pkg::TXQ_OVER_BIT] = status.txQueueOverflow && !is1gkx;
    live[crs_pkg::RXQ_UNDER_BIT] = status.rxQueueUnderflow && !is1gkx;
    live[crs_pkg::RXQ_OVER_BIT] = status.rxQueueOverflow;
    // Link good from the system side has no meaning outside 10G
    live[crs_pkg::SYS_LINK_BIT] = status.systemReceiveLinkGood && (mode == crs_pkg::CRS_MODE_10G);
    live[crs_pkg::INT_LINK_BIT] = status.internalAlignLinkGood;
    live[crs_pkg::HOST_PLL_BIT] = status.hostSerdesPllLocked;
    live[crs_pkg::LINE_PLL_BIT] = status.lineSerdesPllLocked;
  end

  // One latch cell per status bit, kind chosen from the masks
  logic [15:0] held;
  for (genvar i = 0; i < 16; i++) begin : g_bit
    localparam logic [1:0] K = crs_pkg::LIVE_MASK[i] ? 2'h2 :
      (crs_pkg::LATCH_LOW_MASK[i] ? 2'h1 : 2'h0);
    crs_latch_bit #(.KIND(K)) u_bit (
      .clock(clock),
      .arst_n(arst_n),
      .live(live[i]),
      .rdClr(rdStatus),
      .held(held[i])
    );
  end

  // Registered read port; unmapped addresses read zero
  logic [15:0] rdData_q;
  logic rdValid_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 16'h0000;
      rdValid_q <= 1'h0;
    end else begin
      rdValid_q <= req.rdStb;
      if (rdStatus) begin
        rdData_q <= held;
      end else if (rdReset) begin
        // Upper byte reserved and zero; pulse bits read back as zero
        rdData_q <= {8'h00, rsvMid_q, 3'h0, rsvLo_q};
      end else begin
        rdData_q <= 16'h0000;
      end
    end
  end
  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
endmodule : crs_regs

/* verif/crs_regs_chk.sv */
// Purpose: Port checker for the channel reset and status registers
// Assumes: One clock domain, requests sampled on the rising edge
// Notes: Pulses are judged one cycle after the write edge
`timescale 1ns/100ps
module crs_regs_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire crs_pkg::crs_req_s req,
  input wire crs_pkg::crs_mode_e mode,
  input wire crs_pkg::crs_status_s status,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic channelPathReset,
  input wire logic transmitQueueClear,
  input wire logic receiveQueueClear
);
  logic hitC;
  logic hitS;
  logic rdCtrl_q;
  // Address decode of both registers
  assign hitC = req.devAddr == crs_pkg::DEV_ADDR && req.regAddr == crs_pkg::RESET_CTRL_ADDR;
  assign hitS = req.devAddr == crs_pkg::DEV_ADDR && req.regAddr == crs_pkg::STATUS_ONE_ADDR;
  // Remembers a control read so its answer can be judged
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdCtrl_q <= 1'h0;
    else rdCtrl_q <= req.rdStb && hitC;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_pathWr; req.wrStb && hitC && req.wrData[3]; endsequence
  sequence s_rdSt; req.rdStb && hitS; endsequence
  // The live condition must have gone away without a read, so only the latch can still show it
  sequence s_losGone; !status.lineSignalLost && !(req.rdStb && hitS); endsequence
  sequence s_lockBack; status.lineSerdesPllLocked && !(req.rdStb && hitS); endsequence
  property p_rdLat; req.rdStb |=> rdValid; endproperty
  a_rdLat: assert property (p_rdLat) else $error("read answer missing");
  property p_path; s_pathWr |=> channelPathReset; endproperty
  a_path: assert property (p_path) else $error("path reset pulse missing");
  property p_selfClr; s_pathWr ##1 !(req.wrStb && hitC && req.wrData[3]) |=> !channelPathReset; endproperty
  a_selfClr: assert property (p_selfClr) else $error("path reset stuck high");
  property p_txClr; req.wrStb && hitC && req.wrData[2] && mode == crs_pkg::CRS_MODE_10G |=> transmitQueueClear;
  endproperty
  a_txClr: assert property (p_txClr) else $error("transmit clear missing");
  property p_rxOff; mode != crs_pkg::CRS_MODE_10G |=> !receiveQueueClear; endproperty
  a_rxOff: assert property (p_rxOff) else $error("receive clear outside 10G");
  property p_ctrlRsv; rdValid && rdCtrl_q |-> rdData[15:8] == 8'h00; endproperty
  a_ctrlRsv: assert property (p_ctrlRsv) else $error("reserved byte not zero");
  property p_los; status.lineSignalLost ##1 s_losGone ##1 s_rdSt |=> rdData[13]; endproperty
  a_los: assert property (p_los) else $error("signal loss not held");
  property p_pll; !status.lineSerdesPllLocked ##1 s_lockBack ##1 s_rdSt |=> !rdData[0]; endproperty
  a_pll: assert property (p_pll) else $error("lock loss not held");
  property p_pat; req.rdStb && hitS && mode == crs_pkg::CRS_MODE_10GKR |=> !rdData[15]; endproperty
  a_pat: assert property (p_pat) else $error("pattern bit set in 10GKR");
endmodule : crs_regs_chk
bind crs_regs crs_regs_chk u_chk (.clock(clock), .arst_n(arst_n), .req(req), .mode(mode), .status(status),
  .rdData(rdData), .rdValid(rdValid), .channelPathReset(channelPathReset),
  .transmitQueueClear(transmitQueueClear), .receiveQueueClear(receiveQueueClear));

/* verif/crs_host.sv */
// Purpose: Management station model issuing register requests
// Assumes: Requests change just after a rising edge
// Notes: Idle cycles scramble the qualifiers so stale values never pass
`timescale 1ns/100ps
module crs_host (
  input wire logic clock,
  output crs_pkg::crs_req_s req,
  output crs_pkg::crs_mode_e mode
);
  initial begin
    req = '0;
    mode = crs_pkg::CRS_MODE_10G;
  end
  // One request, held for exactly one sampling edge
  task automatic acc(input logic w, input logic r, input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
    @(posedge clock);
    req <= {w, r, d, a, v};
  endtask : acc
  // No strobe, qualifiers inverted
  task automatic idle();
    @(posedge clock);
    req <= {2'h0, ~req[36:0]};
  endtask : idle
  // A new mode is followed by a datapath reset
  task automatic setMode(input crs_pkg::crs_mode_e m);
    @(posedge clock);
    mode <= m;
    req <= {2'h2, crs_pkg::DEV_ADDR, crs_pkg::RESET_CTRL_ADDR, 16'h0008};
  endtask : setMode
endmodule : crs_host

/* verif/tb_crs_regs.sv */
// Purpose: Self-checking bench comparing crs_regs with a reference model
// Assumes: Inputs change on the rising edge by non-blocking assignment
// Notes: Mode stays fixed across reads since it qualifies the read data
`timescale 1ns/100ps
module tb_crs_regs;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  crs_pkg::crs_req_s req;
  crs_pkg::crs_mode_e mode;
  crs_pkg::crs_status_s status = '0;
  logic [15:0] rdData, held, ctrl, expRd;
  logic rdValid, chPath, txClr, rxClr, expVld, expPath, expTx, expRx;
  int num_errors = 0;
  int compares = 0;
  int seed = 32'hD53F;
  always #50 clock = ~clock;
  crs_host host (.clock(clock), .req(req), .mode(mode));
  crs_regs uut (.clock(clock), .arst_n(arst_n), .req(req), .mode(mode), .status(status), .rdData(rdData),
    .rdValid(rdValid), .channelPathReset(chPath), .transmitQueueClear(txClr), .receiveQueueClear(rxClr));
  task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic cmpPulse(input logic got, input logic exp);
    cmpWord({15'h0000, got}, {15'h0000, exp});
  endtask : cmpPulse
  // Reference model; compares see outputs and model state of the same edge
  always @(posedge clock or negedge arst_n) begin
    logic hitC, hitS;
    logic [15:0] q;
    hitC = req.devAddr == 5'h1E && req.regAddr == 16'h000E;
    hitS = req.devAddr == 5'h1E && req.regAddr == 16'h000F;
    q = held;
    if (mode == crs_pkg::CRS_MODE_10GKR) q[15] = 1'h0;
    if (mode == crs_pkg::CRS_MODE_1GKX) q[7:5] = 3'h0;
    if (mode != crs_pkg::CRS_MODE_10G) q[3] = 1'h0;
    if (!arst_n) begin
      {held, ctrl, expRd, expVld, expPath, expTx, expRx} <= '0;
    end else begin
      cmpPulse(rdValid, expVld);
      cmpWord(rdData, expRd);
      cmpPulse(chPath, expPath);
      cmpPulse(txClr, expTx);
      cmpPulse(rxClr, expRx);
      expVld <= req.rdStb;
      expRd <= !req.rdStb ? 16'h0000 : hitC ? ctrl : hitS ? q : 16'h0000;
      expPath <= req.wrStb && hitC && req.wrData[3];
      expTx <= req.wrStb && hitC && req.wrData[2] && mode == crs_pkg::CRS_MODE_10G;
      expRx <= req.wrStb && hitC && req.wrData[1] && mode == crs_pkg::CRS_MODE_10G;
      if (req.wrStb && hitC) ctrl <= req.wrData & 16'h00F1;
      held <= (req.rdStb && hitS) ? status : (held & status & 16'h5C0F) | ((held | status) & 16'h23F0)
        | (status & 16'h8000);
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #2000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'h1;
    for (int m = 0; m < 3; m++) begin
      host.setMode(crs_pkg::crs_mode_e'(m));
      host.acc(1'h1, 1'h0, 5'h1E, 16'h000E, 16'hFFFF);
      host.acc(1'h0, 1'h1, 5'h1E, 16'h000E, 16'h0000);
      host.acc(1'h1, 1'h0, 5'h1E, 16'h000E, 16'h00F6);
      host.acc(1'h0, 1'h1, 5'h1E, 16'h000E, 16'h0000);
      host.acc(1'h1, 1'h0, 5'h1E, 16'h000F, 16'hFFFF);
      host.acc(1'h0, 1'h1, 5'h1D, 16'h000E, 16'h0000);
      host.acc(1'h0, 1'h1, 5'h1E, 16'h0010, 16'h0000);
      repeat (16) begin
        status <= 16'($random(seed));
        host.acc(1'h0, 1'($random(seed)), 5'h1E, 16'h000F, 16'h0000);
      end
      status <= 16'hFFFF;
      host.idle();
      repeat (2) host.acc(1'h0, 1'h1, 5'h1E, 16'h000F, 16'h0000);
      status <= 16'h0000;
      host.idle();
      repeat (2) host.acc(1'h0, 1'h1, 5'h1E, 16'h000F, 16'h0000);
      arst_n <= 1'h0;
      host.idle();
      arst_n <= 1'h1;
      host.acc(1'h0, 1'h1, 5'h1E, 16'h000E, 16'h0000);
      repeat (2) host.idle();
      $display("test %0d done", m);
    end
    tally_and_finish();
  end
endmodule : tb_crs_regs
